/* File: tcu_uart.sv */
`timescale 1ns/1ns
module tcu_uart
  import tcu_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire tcu_cfg_t    i_cfg,
  input  wire logic        i_srv_we,
  input  wire logic [1:0]  i_srv,
  input  wire logic [13:0] i_tx_data,
  input  wire logic        i_status_clr,
  input  wire logic        i_rxd,
  output logic             o_txd,
  output logic [13:0]      o_rx_data,
  output logic             o_parity_err,
  output logic             o_busy,
  output logic             o_status,
  output logic             o_irq
);
  tcu_chan_t s_q;
  tcu_chan_t s_d;
  logic      en;
  logic      st_q;
  logic      st_d;
  logic      irq_q;
  logic      irq_d;
  logic      busy_q;
  logic      busy_d;

  tcu_gate u_gate (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_prio (i_cfg.prio),
    .o_en   (en)
  );

  function automatic logic par_on(input logic [1:0] p);
    return p == PAR_EVEN || p == PAR_ODD;
  endfunction : par_on

  function automatic logic [3:0] clip_len(input logic [3:0] l);
    if (l < 4'(MIN_BITS)) return 4'(MIN_BITS);
    if (l > 4'(MAX_BITS)) return 4'(MAX_BITS);
    return l;
  endfunction : clip_len

  logic [15:0] div;
  logic        tick;
  logic        half;
  logic [3:0]  len;
  logic        rxs;

  // The divider counts only on enabled cycles, so a slower priority stretches
  // the bit time; software picks the divider with that in mind.
  assign div  = (i_cfg.div == 16'h0) ? 16'h1 : i_cfg.div;
  assign tick = en && (s_q.cnt >= div - 16'h1);
  assign half = en && (s_q.cnt >= (div >> 1));
  assign len  = clip_len(i_cfg.len);
  assign rxs  = s_q.sync[1];

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.sync = {s_q.sync[0], i_rxd};
    if (en) begin
      s_d.cnt = s_q.cnt + 16'h1;
    end
    // A disabled channel refuses service codes too, so no start bit can leak.
    if (i_cfg.prio == PRI_OFF) begin
      s_d.st    = ST_IDLE;
      s_d.armed = 1'b0;
      s_d.line  = 1'b1;
    end else if (i_srv_we && i_srv == SRV_TX) begin
      s_d.is_rx = 1'b0;
      s_d.armed = 1'b1;
      s_d.st    = ST_START;
      s_d.cnt   = 16'h0;
      s_d.shf   = i_tx_data;
      s_d.par   = (i_cfg.parity == PAR_ODD);
      s_d.nbit  = 4'h0;
      s_d.line  = 1'b0;
    end else if (i_srv_we && i_srv == SRV_RX) begin
      s_d.is_rx = 1'b1;
      s_d.armed = 1'b1;
      s_d.st    = ST_IDLE;
      s_d.line  = 1'b1;
    end else if (!s_q.is_rx) begin
      case (s_q.st)
        ST_IDLE: begin
          s_d.line = 1'b1;
        end
        ST_START: begin
          if (tick) begin
            s_d.cnt  = 16'h0;
            s_d.st   = ST_DATA;
            s_d.line = s_q.shf[0];
          end
        end
        ST_DATA: begin
          if (tick) begin
            s_d.cnt  = 16'h0;
            s_d.par  = s_q.par ^ s_q.shf[0];
            s_d.shf  = {1'b0, s_q.shf[13:1]};
            s_d.nbit = s_q.nbit + 4'h1;
            if (s_q.nbit + 4'h1 == len) begin
              if (par_on(i_cfg.parity)) begin
                s_d.st   = ST_PAR;
                s_d.line = s_q.par ^ s_q.shf[0];
              end else begin
                s_d.st   = ST_STOP;
                s_d.line = 1'b1;
              end
            end else begin
              s_d.line = s_q.shf[1];
            end
          end
        end
        ST_PAR: begin
          if (tick) begin
            s_d.cnt  = 16'h0;
            s_d.st   = ST_STOP;
            s_d.line = 1'b1;
          end
        end
        ST_STOP: begin
          if (tick) begin
            s_d.st    = ST_IDLE;
            s_d.armed = 1'b0;
            s_d.done  = 1'b1;
          end
        end
        default: s_d.st = ST_IDLE;
      endcase
    end else if (s_q.armed) begin
      // Receiver samples mid-bit; a start bit gone high by then is a glitch.
      case (s_q.st)
        ST_IDLE: begin
          s_d.cnt = 16'h0;
          if (!rxs) begin
            s_d.st = ST_START;
          end
        end
        ST_START: begin
          if (half) begin
            s_d.cnt  = 16'h0;
            s_d.nbit = 4'h0;
            s_d.shf  = 14'h0;
            s_d.par  = (i_cfg.parity == PAR_ODD);
            s_d.st   = rxs ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (tick) begin
            s_d.cnt  = 16'h0;
            s_d.par  = s_q.par ^ rxs;
            s_d.shf  = s_q.shf | (14'(rxs) << s_q.nbit);
            s_d.nbit = s_q.nbit + 4'h1;
            if (s_q.nbit + 4'h1 == len) begin
              s_d.st = par_on(i_cfg.parity) ? ST_PAR : ST_STOP;
            end
          end
        end
        ST_PAR: begin
          if (tick) begin
            s_d.cnt  = 16'h0;
            s_d.perr = s_q.par ^ rxs;
            s_d.st   = ST_STOP;
          end
        end
        ST_STOP: begin
          if (tick) begin
            s_d.st   = ST_IDLE;
            s_d.word = s_q.shf;
            s_d.done = 1'b1;
            if (!par_on(i_cfg.parity)) begin
              s_d.perr = 1'b0;
            end
          end
        end
        default: s_d.st = ST_IDLE;
      endcase
    end
    st_d  = s_q.done ? 1'b1 : (i_status_clr ? 1'b0 : st_q);
    irq_d = st_d && i_cfg.int_en;
    busy_d = s_d.st != ST_IDLE;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q      <= '0;
      s_q.st   <= ST_IDLE;
      s_q.line <= 1'b1;
      s_q.sync <= 2'h3;
      st_q     <= 1'b0;
      irq_q    <= 1'b0;
      busy_q   <= 1'b0;
    end else begin
      s_q    <= s_d;
      st_q   <= st_d;
      irq_q  <= irq_d;
      busy_q <= busy_d;
    end
  end

  assign o_txd        = s_q.line;
  assign o_rx_data    = s_q.word;
  assign o_parity_err = s_q.perr;
  assign o_busy       = busy_q;
  assign o_status     = st_q;
  assign o_irq        = irq_q;
endmodule : tcu_uart

/* File: tcu_pkg.sv */
package tcu_pkg;
  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned MAX_BITS       = 14;
  localparam int unsigned MIN_BITS       = 1;
  localparam logic [1:0]  PAR_EVEN       = 2'h2;
  localparam logic [1:0]  PAR_ODD        = 2'h3;
  localparam logic [1:0]  SRV_TX         = 2'h2;
  localparam logic [1:0]  SRV_RX         = 2'h3;
  localparam logic [1:0]  PRI_OFF        = 2'h0;
  localparam logic [15:0] BAUD_DIV_RST   = 16'h01b2;
  localparam logic [3:0]  LEN_RST        = 4'h8;
  localparam logic [1:0]  PRI_HOLD_LOW   = 2'h3;
  localparam logic [1:0]  PRI_HOLD_MED   = 2'h1;

  typedef struct packed {
    logic [1:0]  parity;
    logic [1:0]  prio;
    logic [3:0]  len;
    logic [15:0] div;
    logic        int_en;
  } tcu_cfg_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP
  } tcu_state_t;

  typedef struct packed {
    tcu_state_t  st;
    logic        is_rx;
    logic        armed;
    logic [15:0] cnt;
    logic [3:0]  nbit;
    logic [13:0] shf;
    logic        par;
    logic        line;
    logic        done;
    logic        perr;
    logic [13:0] word;
    logic [1:0]  sync;
  } tcu_chan_t;
endpackage : tcu_pkg

/* File: tcu_gate.sv */
`timescale 1ns/1ns
// Turns the priority field into a service enable: low priority runs one
// bit-clock step in four, medium one in two, high every cycle.
module tcu_gate
  import tcu_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [1:0] i_prio,
  output logic            o_en
);
  logic [1:0] ph_q;
  logic [1:0] ph_d;

  always_comb begin
    ph_d = ph_q + 2'h1;
    case (i_prio)
      PRI_OFF: o_en = 1'b0;
      2'h1:    o_en = (ph_q == PRI_HOLD_LOW);
      2'h2:    o_en = ph_q[0] == PRI_HOLD_MED[0];
      default: o_en = 1'b1;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ph_q <= 2'h0;
    end else begin
      ph_q <= ph_d;
    end
  end
endmodule : tcu_gate

/* File: tcu_uart_properties.sv */
`timescale 1ns/1ns
module tcu_uart_properties
  import tcu_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire tcu_cfg_t    i_cfg,
  input wire logic        i_srv_we,
  input wire logic [1:0]  i_srv,
  input wire logic [13:0] i_tx_data,
  input wire logic        i_status_clr,
  input wire logic        i_rxd,
  input wire logic        o_txd,
  input wire logic [13:0] o_rx_data,
  input wire logic        o_parity_err,
  input wire logic        o_busy,
  input wire logic        o_status,
  input wire logic        o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  AST_TX_START: assert property (
    i_srv_we && i_srv == SRV_TX && i_cfg.prio == 2'h3 |=> !o_txd) else $error("no start bit");
  AST_BIT_LEN: assert property (
    i_srv_we && i_srv == SRV_TX && i_cfg.prio == 2'h3 && i_cfg.div == 16'h0004
    |=> !o_txd [*4] ##1 (o_txd == i_tx_data[0])) else $error("start bit length wrong");
  AST_IGNORE: assert property (
    i_srv_we && !i_srv[1] && !o_busy && i_rxd |=> !o_busy) else $error("unused code acted");
  AST_OFF: assert property (
    i_cfg.prio == PRI_OFF [*2] |-> o_txd && !o_busy) else $error("disabled channel active");
  AST_IDLE: assert property (!o_busy |-> o_txd) else $error("line low while idle");
  AST_DONE: assert property (
    $fell(o_busy) && i_cfg.prio != PRI_OFF && $past(i_cfg.prio) != PRI_OFF |-> ##[0:2] o_status)
    else $error("no status after word");
  AST_HOLD: assert property (
    o_status && !i_status_clr |=> o_status) else $error("status lost");
  // The request follows status on the same edge, gated by the enable seen one edge before.
  AST_IRQ: assert property (
    o_irq == (o_status && $past(i_cfg.int_en))) else $error("irq wrong");
  cover property (i_srv_we && i_srv == SRV_RX);
  cover property ($rose(o_irq));
  cover property (o_parity_err && o_status);
endmodule : tcu_uart_properties
bind tcu_uart tcu_uart_properties u_props (.i_clk(i_clk), .i_rst(i_rst), .i_cfg(i_cfg),
  .i_srv_we(i_srv_we), .i_srv(i_srv), .i_tx_data(i_tx_data), .i_status_clr(i_status_clr),
  .i_rxd(i_rxd), .o_txd(o_txd), .o_rx_data(o_rx_data), .o_parity_err(o_parity_err),
  .o_busy(o_busy), .o_status(o_status), .o_irq(o_irq));

/* File: tcu_peer.sv */
`timescale 1ns/1ns
module tcu_peer
  import tcu_pkg::*;
(
  input  wire logic i_line,
  output logic      o_line
);
  initial o_line = 1'b1;
  // A flipped parity bit lets the bench see the receiver's check at work.
  task automatic send(input logic [13:0] w, input int n, input logic [1:0] par,
                      input int bt, input logic bad);
    o_line = 1'b0;
    #(bt);
    for (int i = 0; i < n; i++) begin
      o_line = w[i];
      #(bt);
    end
    if (par[1]) begin
      o_line = (^w) ^ par[0] ^ bad;
      #(bt);
    end
    o_line = 1'b1;
    #(bt);
  endtask : send
  // Returns in the middle of the stop bit, so the caller can check its level.
  task automatic recv(input int n, input logic [1:0] par, input int bt,
                      output logic [13:0] w, output logic p);
    w = 14'h0000;
    p = 1'b0;
    for (int k = 0; k < 5000 && i_line; k++) #1;
    #(bt / 2 + bt);
    for (int i = 0; i < n; i++) begin
      w[i] = i_line;
      #(bt);
    end
    if (par[1]) begin
      p = i_line;
      #(bt);
    end
  endtask : recv
endmodule : tcu_peer

/* File: tb.sv */
`timescale 1ns/1ns
module tb
  import tcu_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1, srv_we, status_clr;
  logic [1:0]  srv;
  logic [13:0] tx_data, rx_data;
  tcu_cfg_t    cfg;
  wire logic   rxd;
  logic        txd, parity_err, busy, status, irq;
  int          fail_count = 0, samples_checked = 0;
  always #10 clk = ~clk;
  tcu_uart dut (.i_clk(clk), .i_rst(rst), .i_cfg(cfg), .i_srv_we(srv_we), .i_srv(srv),
    .i_tx_data(tx_data), .i_status_clr(status_clr), .i_rxd(rxd), .o_txd(txd),
    .o_rx_data(rx_data), .o_parity_err(parity_err), .o_busy(busy), .o_status(status),
    .o_irq(irq));
  tcu_peer peer (.i_line(txd), .o_line(rxd));
  task end_of_test;
    $display("compared %0d, mismatched %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  task chk(input logic [13:0] got, input logic [13:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [13:0] mask(input int n);
    return 14'h3fff >> (14 - n);
  endfunction : mask
  task srv_write(input logic [1:0] code);
    @(negedge clk) srv = code;
    srv_we = 1'b1;
    @(negedge clk) srv_we = 1'b0;
  endtask : srv_write
  // Every wait is bounded so a stuck channel ends the run instead of hanging it.
  task wait_done;
    for (int k = 0; k < 5000 && status !== 1'b1; k++) @(negedge clk);
    if (status !== 1'b1) begin
      chk(14'(status), 14'h0001);
      end_of_test;
    end
  endtask : wait_done
  task clear;
    status_clr = 1'b1;
    @(negedge clk) status_clr = 1'b0;
    @(negedge clk) chk(14'(status), 14'h0000);
  endtask : clear
  task t_tx(input logic [13:0] w, input int n, input logic [1:0] par, input logic [1:0] pr);
    logic [13:0] got;
    logic        p;
    int          mul;
    mul = (pr == 2'h1) ? 4 : (pr == 2'h2) ? 2 : 1;
    cfg = '{parity: par, prio: pr, len: 4'(n), div: 16'h0004, int_en: pr[0]};
    tx_data = w;
    srv_write(SRV_TX);
    peer.recv(n, par, 80 * mul, got, p);
    chk(got, w & mask(n));
    if (par[1]) chk(14'(p), 14'((^(w & mask(n))) ^ par[0]));
    chk(14'(txd), 14'h0001);
    wait_done;
    @(negedge clk);
    @(negedge clk) chk(14'(irq), 14'(pr[0]));
    clear;
  endtask : t_tx
  task t_rx(input logic [13:0] w, input int n, input logic [1:0] par, input logic bad);
    cfg = '{parity: par, prio: 2'h3, len: 4'(n), div: 16'h0008, int_en: 1'b1};
    srv_write(SRV_RX);
    peer.send(w & mask(n), n, par, 160, bad);
    wait_done;
    chk(rx_data, w & mask(n));
    chk(14'(parity_err), 14'(bad & par[1]));
    clear;
  endtask : t_rx
  task t_ignore;
    for (int c = 0; c < 2; c++) begin
      srv_write(2'(c));
      repeat (3) @(negedge clk);
      chk(14'({busy, txd}), 14'h0001);
    end
  endtask : t_ignore
  task t_off;
    cfg = '{parity: 2'h2, prio: 2'h3, len: 4'h8, div: 16'h0004, int_en: 1'b1};
    tx_data = 14'h0000;
    srv_write(SRV_TX);
    repeat (6) @(negedge clk);
    cfg.prio = PRI_OFF;
    repeat (3) @(negedge clk);
    chk(14'({busy, txd}), 14'h0001);
    repeat (200) @(negedge clk);
    chk(14'(status), 14'h0000);
  endtask : t_off
  initial begin
    cfg = '{parity: 2'h0, prio: 2'h3, len: LEN_RST, div: 16'h0004, int_en: 1'b0};
    {srv_we, srv, tx_data, status_clr} = '0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    t_tx(14'h0001, 1, 2'h0, 2'h3);
    t_tx(14'h2ac5, 14, 2'h1, 2'h3);
    t_tx(14'h00a5, 8, 2'h2, 2'h3);
    t_tx(14'h0016, 5, 2'h3, 2'h2);
    t_tx(14'h3a5c, 14, 2'h3, 2'h1);
    t_rx(14'h3c96, 14, 2'h2, 1'b0);
    t_rx(14'h0005, 3, 2'h3, 1'b1);
    t_rx(14'h0001, 1, 2'h1, 1'b1);
    t_ignore;
    t_off;
    end_of_test;
  end
endmodule : tb
